// ### drive_link_chk.sv
`timescale 1ns/1ps
module drive_link_chk (
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        reset_n_i,
  // link signals
  input wire logic [15:0] cmd_word,
  input wire logic        cmd_valid,
  input wire logic [7:0]  mode_code,
  input wire logic [15:0] state_word
);
  // ------------------------------------------------------------
  // link checks, state answers two edges after the command pulse, the running bit 12 three edges after a start
  // ------------------------------------------------------------
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  AST_RESET_STATE: assert property ($rose(reset_n_i) |-> state_word == 16'h0050)
    else $error("state word not disabled after reset");
  AST_DISABLE: assert property (cmd_valid && cmd_word == 16'h0000 |-> ##2 state_word == 16'h0050)
    else $error("zero command did not disable");
  AST_READY: assert property (cmd_valid && cmd_word == 16'h0006 && state_word == 16'h0050
    |-> ##2 state_word == 16'h0031)
    else $error("shutdown did not give ready");
  AST_SWITCH_ON: assert property (cmd_valid && cmd_word == 16'h0007 && state_word == 16'h0031
    |-> ##2 state_word == 16'h0033)
    else $error("switch on did not give switched on");
  AST_ENABLE: assert property (cmd_valid && cmd_word[3:0] == 4'hf && state_word[7:0] == 8'h33
    |-> ##2 state_word[7:0] == 8'h37)
    else $error("enable did not reach operation enabled");
  AST_SUBSTATE: assert property ($rose(state_word[12]) |-> cmd_word[3:0] == 4'hf)
    else $error("sub-state changed outside operation enabled");
  AST_STOP: assert property (cmd_valid && cmd_word == 16'h0007 && state_word[7:0] == 8'h37
    && mode_code == drive_mode_pkg::MODE_INTERP |-> ##2 !state_word[12] && state_word[7:0] == 8'h33)
    else $error("drop to switch on did not stop interpolation");
  AST_MODE_GUARD: assert property (!$stable(mode_code) |-> $past(state_word[7:0]) == 8'h33)
    else $error("mode changed outside switched on");
  // the running flag is registered once more than the power state, so bit 12 lags by one edge
  AST_INTERP_START: assert property (cmd_valid && cmd_word == 16'h001f && state_word[7:0] == 8'h37
    && mode_code == drive_mode_pkg::MODE_INTERP |-> ##3 state_word[12] && state_word[7:0] == 8'h37)
    else $error("interpolation did not start");
  AST_HALT: assert property (cmd_valid && cmd_word == 16'h011f
    && mode_code == drive_mode_pkg::MODE_HOMING |-> ##2 !state_word[10] && state_word[7:0] == 8'h37)
    else $error("halt did not decelerate while enabled");
  AST_HOME_FLAGS: assert property (state_word[13] |-> !state_word[12])
    else $error("homing attained and error both set");
endmodule

// ### drive_link_if.sv
`timescale 1ns/1ps
interface drive_link_if;
  logic [15:0] cmd_word;
  logic        cmd_valid;
  logic [7:0]  mode_code;
  logic [15:0] state_word;

  modport master (output cmd_word, output cmd_valid, output mode_code, input state_word);
  modport drive  (input cmd_word, input cmd_valid, input mode_code, output state_word);
endinterface

// ### drive_master_ctrl.sv
`timescale 1ns/1ps
module drive_master_ctrl (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [7:0]  haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // interrupt
  output logic             irq_o,
  // link to the drive
  drive_link_if.master     link
);
  logic        wr_pend_reg;
  logic        rd_pend_reg;
  logic [7:0]  addr_reg;
  logic [7:0]  mode_reg;
  logic [15:0] cmd_reg;
  logic        cmd_valid_reg;
  localparam int IRQ_W = drive_mode_pkg::IRQ_WIDTH;
  logic [15:0] state_prev_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_mask_reg;

  wire take = hsel_i && hready_i && (htrans_i == drive_mode_pkg::HTRANS_NONSEQ);
  wire rd_status = rd_pend_reg && (addr_reg == drive_mode_pkg::ADDR_IRQ_STATUS);
  wire sw_on = (link.state_word[7:0] == drive_mode_pkg::STATE_SW_ON_LOW);
  wire [IRQ_W-1:0] events;

  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign irq_o       = |(irq_status_reg & irq_mask_reg);
  assign link.cmd_word  = cmd_reg;
  assign link.cmd_valid = cmd_valid_reg;
  assign link.mode_code = mode_reg;
  assign events[drive_mode_pkg::IRQ_STATE_CHANGE] = (link.state_word != state_prev_reg);
  assign events[drive_mode_pkg::IRQ_HOMED] = link.state_word[drive_mode_pkg::BIT_ATTAINED] &
                                            !state_prev_reg[drive_mode_pkg::BIT_ATTAINED];
  assign events[drive_mode_pkg::IRQ_HOME_ERR] = link.state_word[drive_mode_pkg::BIT_HOME_ERR] &
                                               !state_prev_reg[drive_mode_pkg::BIT_HOME_ERR];

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= '0;
    end else begin
      wr_pend_reg <= take && hwrite_i;
      rd_pend_reg <= take && !hwrite_i;
      if (take) begin
        addr_reg <= haddr_i;
      end
    end
  end

  // ---------------------------------
  // command and mode registers
  // ---------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_reg       <= drive_mode_pkg::CMD_DISABLE;
      cmd_valid_reg <= 1'b0;
      mode_reg      <= '0;
    end else begin
      cmd_valid_reg <= 1'b0;
      if (wr_pend_reg && addr_reg == drive_mode_pkg::ADDR_CMD) begin
        cmd_reg       <= hwdata_i[15:0];
        cmd_valid_reg <= 1'b1;
      end
      // mode change only while switched on
      if (wr_pend_reg && addr_reg == drive_mode_pkg::ADDR_MODE && sw_on) begin
        mode_reg <= hwdata_i[7:0];
      end
    end
  end

  // ---------------------------------
  // interrupts
  // ---------------------------------
  // an event in the clearing read cycle survives the clear
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_status_reg <= '0;
      irq_mask_reg   <= '0;
      state_prev_reg <= drive_mode_pkg::STATE_SW_DISABLED;
    end else begin
      state_prev_reg <= link.state_word;
      irq_status_reg <= (rd_status ? '0 : irq_status_reg) | events;
      if (wr_pend_reg && addr_reg == drive_mode_pkg::ADDR_IRQ_MASK) begin
        irq_mask_reg <= hwdata_i[IRQ_W-1:0];
      end
    end
  end

  always_comb begin
    hrdata_o = 32'h0000_0000;
    if (rd_pend_reg) begin
      unique case (addr_reg)
        drive_mode_pkg::ADDR_CMD:        hrdata_o = {16'h0000, cmd_reg};
        drive_mode_pkg::ADDR_MODE:       hrdata_o = {24'h000000, mode_reg};
        drive_mode_pkg::ADDR_STATE:      hrdata_o = {16'h0000, link.state_word};
        drive_mode_pkg::ADDR_IRQ_STATUS: hrdata_o = {29'h0, irq_status_reg};
        drive_mode_pkg::ADDR_IRQ_MASK:   hrdata_o = {29'h0, irq_mask_reg};
        default:                         hrdata_o = 32'h0000_0000;
      endcase
    end
  end
endmodule

// ### drive_mode_ctrl.sv
`timescale 1ns/1ps
module drive_mode_ctrl #(
  parameter int HOME_CYCLES  = 64,
  parameter int DECEL_CYCLES = 16
) (
  // clock and reset
  input  wire logic  sys_clk_i,
  input  wire logic  reset_n_i,
  // link to the master
  drive_link_if.drive link,
  // motion plant status
  input  wire logic  home_switch_i,
  input  wire logic  home_fault_i,
  // motion outputs
  output logic       axle_moving_o,
  output logic       decel_active_o,
  output logic [15:0] ramp_param_o
);
  typedef enum logic [1:0] {SW_DISABLED, READY, SWITCHED_ON, OP_ENABLED} power_t;

  power_t      power_reg;
  logic [15:0] cmd_reg;
  logic        start_prev_reg;
  logic        homing_reg;
  logic        interp_running_flag;
  logic        attained_reg;
  logic        home_err_reg;
  logic        target_reg;
  logic        halt_prev_reg;
  logic [15:0] count_reg;
  logic        sw_q1_reg;
  logic        sw_q2_reg;
  logic        flt_q1_reg;
  logic        flt_q2_reg;

  wire enabled  = (power_reg == OP_ENABLED);
  wire in_homing = (link.mode_code == drive_mode_pkg::MODE_HOMING);
  wire in_interp = (link.mode_code == drive_mode_pkg::MODE_INTERP);
  wire halt     = cmd_reg[drive_mode_pkg::BIT_HALT];
  wire motion_ok = enabled && (cmd_reg[3:0] == drive_mode_pkg::CMD_ENABLED_NIBBLE);
  wire start_lvl = motion_ok && cmd_reg[drive_mode_pkg::BIT_START];

  assign ramp_param_o = drive_mode_pkg::HOMING_RAMP_PARAM;

  // ---------------------------------
  // pin synchronisers
  // ---------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sw_q1_reg  <= 1'b0;
      sw_q2_reg  <= 1'b0;
      flt_q1_reg <= 1'b0;
      flt_q2_reg <= 1'b0;
    end else begin
      sw_q1_reg  <= home_switch_i;
      sw_q2_reg  <= sw_q1_reg;
      flt_q1_reg <= home_fault_i;
      flt_q2_reg <= flt_q1_reg;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_reg <= drive_mode_pkg::CMD_DISABLE;
    end else if (link.cmd_valid) begin
      cmd_reg <= link.cmd_word;
    end
  end

  // ---------------------------------
  // power state sequence
  // ---------------------------------
  // reset to switch-on-disabled
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      power_reg <= SW_DISABLED;
    end else if (link.cmd_valid) begin
      if (link.cmd_word[3:0] == 4'h0 || link.cmd_word[1] == 1'b0) begin
        power_reg <= SW_DISABLED;
      end else if (link.cmd_word[3:0] == drive_mode_pkg::CMD_SHUTDOWN[3:0]) begin
        power_reg <= READY;
      end else if (link.cmd_word[3:0] == drive_mode_pkg::CMD_SWITCH_ON[3:0]) begin
        if (power_reg != SW_DISABLED) begin
          power_reg <= SWITCHED_ON;
        end
      end else if (link.cmd_word[3:0] == drive_mode_pkg::CMD_ENABLED_NIBBLE) begin
        if (power_reg == SWITCHED_ON || power_reg == OP_ENABLED) begin
          power_reg <= OP_ENABLED;
        end
      end
    end
  end

  // ---------------------------------
  // motion sub-states
  // ---------------------------------
  // halt ends homing but keeps its attained and error flags; homing only restarts from a fresh rising edge
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      start_prev_reg      <= 1'b0;
      homing_reg          <= 1'b0;
      interp_running_flag <= 1'b0;
      attained_reg        <= 1'b0;
      home_err_reg        <= 1'b0;
      count_reg           <= '0;
      target_reg          <= 1'b0;
      halt_prev_reg       <= 1'b0;
    end else begin
      start_prev_reg <= start_lvl;
      halt_prev_reg  <= halt;
      interp_running_flag <= in_interp && start_lvl;
      if (!motion_ok) begin
        homing_reg <= 1'b0;
        count_reg  <= '0;
        target_reg <= 1'b0;
      end else if (halt) begin
        homing_reg <= 1'b0;
        if (!halt_prev_reg) begin
          // a fresh halt times its own ramp, not what homing left in the counter
          count_reg  <= '0;
          target_reg <= 1'b0;
        end else if (count_reg < 16'(DECEL_CYCLES)) begin
          count_reg  <= count_reg + 16'd1;
          target_reg <= 1'b0;
        end else begin
          target_reg <= 1'b1;
        end
      end else if (in_homing) begin
        if (start_lvl && !start_prev_reg) begin
          homing_reg   <= 1'b1;
          attained_reg <= 1'b0;
          home_err_reg <= 1'b0;
          target_reg   <= 1'b0;
          count_reg    <= '0;
        end else if (!start_lvl) begin
          homing_reg <= 1'b0;
          count_reg  <= '0;
        end else if (homing_reg) begin
          count_reg <= count_reg + 16'd1;
          if (flt_q2_reg || count_reg == 16'(HOME_CYCLES - 1)) begin
            homing_reg   <= 1'b0;
            home_err_reg <= 1'b1;
          end else if (sw_q2_reg) begin
            homing_reg   <= 1'b0;
            attained_reg <= 1'b1;
            target_reg   <= 1'b1;
          end
        end
      end else begin
        count_reg <= '0;
      end
    end
  end

  assign axle_moving_o  = homing_reg | interp_running_flag;
  assign decel_active_o = motion_ok && halt && !target_reg;

  // ---------------------------------
  // state word
  // ---------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      link.state_word <= drive_mode_pkg::STATE_SW_DISABLED;
    end else begin
      unique case (power_reg)
        SW_DISABLED: link.state_word <= drive_mode_pkg::STATE_SW_DISABLED;
        READY:       link.state_word <= drive_mode_pkg::STATE_READY;
        SWITCHED_ON: link.state_word <= drive_mode_pkg::STATE_SWITCHED_ON;
        OP_ENABLED: begin
          link.state_word <= drive_mode_pkg::STATE_OP_ENABLED;
          link.state_word[drive_mode_pkg::BIT_TARGET] <= target_reg;
          link.state_word[drive_mode_pkg::BIT_ATTAINED] <=
            in_homing ? attained_reg : interp_running_flag;
          link.state_word[drive_mode_pkg::BIT_HOME_ERR] <= in_homing & home_err_reg;
        end
      endcase
    end
  end
endmodule

// ### drive_mode_pkg.sv
package drive_mode_pkg;
  // object dictionary indices of the exchanged words, and the homing ramp parameter value
  localparam logic [15:0] CMD_WORD_INDEX     = 16'h6040;
  localparam logic [15:0] STATE_WORD_INDEX   = 16'h6041;
  localparam logic [15:0] MODE_INDEX         = 16'h6060;
  localparam logic [15:0] HOMING_RAMP_PARAM  = 16'h046f;
  // operating mode codes
  localparam logic [7:0]  MODE_HOMING        = 8'h06;
  localparam logic [7:0]  MODE_INTERP        = 8'h07;
  // command words
  localparam logic [15:0] CMD_DISABLE        = 16'h0000;
  localparam logic [15:0] CMD_SHUTDOWN       = 16'h0006;
  localparam logic [15:0] CMD_SWITCH_ON      = 16'h0007;
  localparam logic [15:0] CMD_ENABLE         = 16'h000f;
  localparam logic [15:0] CMD_ENABLE_START   = 16'h001f;
  localparam logic [3:0]  CMD_ENABLED_NIBBLE = 4'hf;
  // state words
  localparam logic [15:0] STATE_SW_DISABLED  = 16'h0050;
  localparam logic [15:0] STATE_READY        = 16'h0031;
  localparam logic [15:0] STATE_SWITCHED_ON  = 16'h0033;
  localparam logic [15:0] STATE_OP_ENABLED   = 16'h0037;
  localparam logic [7:0]  STATE_SW_ON_LOW    = 8'h33;
  // bit positions
  localparam int          BIT_START          = 4;
  localparam int          BIT_HALT           = 8;
  localparam int          BIT_TARGET         = 10;
  localparam int          BIT_ATTAINED       = 12;
  localparam int          BIT_HOME_ERR       = 13;
  // controller registers (AHB-Lite byte addresses)
  localparam logic [7:0]  ADDR_CMD           = 8'h00;
  localparam logic [7:0]  ADDR_MODE          = 8'h04;
  localparam logic [7:0]  ADDR_STATE         = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_STATUS    = 8'h0c;
  localparam logic [7:0]  ADDR_IRQ_MASK      = 8'h10;
  // interrupt status bits
  localparam int          IRQ_STATE_CHANGE   = 0;
  localparam int          IRQ_HOMED          = 1;
  localparam int          IRQ_HOME_ERR       = 2;
  localparam int          IRQ_WIDTH          = 3;

  typedef enum logic [1:0] {HTRANS_IDLE = 2'b00, HTRANS_NONSEQ = 2'b10} htrans_t;
endpackage

// ### test_drive_homing_mode_control.sv
`timescale 1ns/1ps
module test_drive_homing_mode_control;
  logic        sys_clk;
  logic        reset_n;
  logic        hwrite;
  logic        home_switch;
  logic        home_fault;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata;
  logic [31:0] rdata;
  wire logic [31:0] hrdata;
  wire logic [15:0] ramp_param;
  wire logic   hready;
  wire logic   irq;
  wire logic   hresp;
  wire logic   axle_moving;
  wire logic   decel_active;
  int          n_errors;
  int          n_tests;
  logic [63:0] rows [11];

  drive_link_if drive_link_if_i ();
  drive_master_ctrl drive_master_ctrl_i (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .hsel_i(1'b1),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .irq_o(irq),
    .link(drive_link_if_i));
  drive_mode_ctrl #(.HOME_CYCLES(64), .DECEL_CYCLES(16)) drive_mode_ctrl_i (.sys_clk_i(sys_clk),
    .reset_n_i(reset_n), .link(drive_link_if_i), .home_switch_i(home_switch), .home_fault_i(home_fault),
    .axle_moving_o(axle_moving), .decel_active_o(decel_active), .ramp_param_o(ramp_param));
  drive_link_chk drive_link_chk_i (.sys_clk_i(sys_clk), .reset_n_i(reset_n),
    .cmd_word(drive_link_if_i.cmd_word), .cmd_valid(drive_link_if_i.cmd_valid),
    .mode_code(drive_link_if_i.mode_code), .state_word(drive_link_if_i.state_word));

  // ------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // hready and read data are taken at the negedge, which equals the value at the next edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    logic ok;
    htrans <= drive_mode_pkg::HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= wr;
    do begin
      @(negedge sys_clk) ok = hready;
      @(posedge sys_clk);
    end while (ok !== 1'b1);
    htrans <= drive_mode_pkg::HTRANS_IDLE;
    hwdata <= wd;
    do begin
      @(negedge sys_clk) ok = hready;
      rdata = hrdata;
      @(posedge sys_clk);
    end while (ok !== 1'b1);
  endtask

  // the drive answers two edges after the command pulse
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, {16'h0000, d});
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    bus(1'b0, a, 32'h0000_0000);
    check(rdata & {16'h0000, m}, {16'h0000, e});
    check({31'h0, hresp}, 32'h0);
  endtask

  task automatic wrap_up;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial begin
    #100us;
    n_errors++;
    $display("watchdog expired");
    wrap_up;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    hwrite = 1'b0;
    haddr = 8'h00;
    htrans = drive_mode_pkg::HTRANS_IDLE;
    hwdata = 32'h0000_0000;
    home_switch = 1'b0;
    home_fault = 1'b0;
    n_errors = 0;
    n_tests = 0;
    // write addr, data, read addr, mask, expected
    rows = '{{8'h00, 16'h0000, 8'h08, 16'hffff, 16'h0050},
             {8'h04, 16'h0007, 8'h04, 16'h00ff, 16'h0000},
             {8'h00, 16'h0006, 8'h08, 16'hffff, 16'h0031},
             {8'h00, 16'h0007, 8'h08, 16'hffff, 16'h0033},
             {8'h04, 16'h0007, 8'h04, 16'h00ff, 16'h0007},
             {8'h00, 16'h000f, 8'h08, 16'h10ff, 16'h0037},
             {8'h00, 16'h001f, 8'h08, 16'hf0ff, 16'h1037},
             {8'h00, 16'h0007, 8'h08, 16'h10ff, 16'h0033},
             {8'h00, 16'h001f, 8'h08, 16'hf0ff, 16'h1037},
             {8'h00, 16'h0007, 8'h08, 16'h10ff, 16'h0033},
             {8'h04, 16'h0006, 8'h04, 16'h00ff, 16'h0006}};
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    check({16'h0000, ramp_param}, 32'h0000_046f);
    foreach (rows[i]) begin
      wr(rows[i][63:56], rows[i][55:40]);
      rd(rows[i][39:32], rows[i][31:16], rows[i][15:0]);
    end
    $display("table done");
    wr(8'h10, 16'h0000);
    wr(8'h00, 16'h000f);
    rd(8'h08, 16'h10ff, 16'h0037);
    bus(1'b0, 8'h0c, 32'h0000_0000);
    wr(8'h00, 16'h001f);
    rd(8'h08, 16'h3000, 16'h0000);
    check({31'h0, axle_moving}, 32'h1);
    home_switch <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(8'h08, 16'hf4ff, 16'h1437);
    check({31'h0, irq}, 32'h0);
    wr(8'h10, 16'h0002);
    check({31'h0, irq}, 32'h1);
    rd(8'h0c, 16'h0002, 16'h0002);
    @(posedge sys_clk);
    check({31'h0, irq}, 32'h0);
    $display("homing done");
    home_switch <= 1'b0;
    wr(8'h00, 16'h000f);
    wr(8'h00, 16'h001f);
    rd(8'h08, 16'h1000, 16'h0000);
    wr(8'h00, 16'h011f);
    rd(8'h08, 16'h04ff, 16'h0037);
    check({31'h0, decel_active}, 32'h1);
    repeat (20) @(posedge sys_clk);
    rd(8'h08, 16'h04ff, 16'h0437);
    $display("halt done");
    wr(8'h00, 16'h000f);
    wr(8'h00, 16'h001f);
    home_fault <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(8'h08, 16'h3000, 16'h2000);
    home_fault <= 1'b0;
    wr(8'h1c, 16'hffff);
    rd(8'h1c, 16'hffff, 16'h0000);
    $display("error and unmapped done");
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(8'h08, 16'hffff, 16'h0050);
    rd(8'h04, 16'h00ff, 16'h0000);
    $display("reset done");
    wrap_up;
  end
endmodule
